// ===== verilog/stp_port_state.sv
// spanning tree port state control with its register port
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
`include "stp_defines.svh"
module stp_port_state (
   // clock, reset and freeze
   input  wire logic                    MCLK_I,
   input  wire logic                    RST_N_I,
   input  wire logic                    CE_I,
   // register port
   input  wire logic [`STP_ADDR_W-1:0]  REG_ADDR_I,
   input  wire logic [`STP_DATA_W-1:0]  REG_WDATA_I,
   input  wire logic                    REG_WR_I,
   input  wire logic                    REG_RD_I,
   output logic      [`STP_DATA_W-1:0]  REG_RDATA_O,
   // frame descriptors from lookup
   input  wire logic                    FRM_VALID_I,
   input  wire stp_pkg::stp_frame_s     FRM_I,
   output logic                         FRM_READY_O,
   // forwarding decisions to queueing
   output logic                         DEC_VALID_O,
   output stp_pkg::stp_dec_s            DEC_O,
   input  wire logic                    DEC_READY_I
);

   localparam int NP = `STP_NUM_PORTS;
   localparam int DW = $bits(stp_pkg::stp_dec_s);

   ////////////////////////////////////////////////////////////////////////
   // decoding helpers

   // one-hot select of the per-port control registers
   function automatic logic [NP-1:0] port_sel(
      input logic [`STP_ADDR_W-1:0] a
   );
      port_sel = {a == `STP_P4_OFS, a == `STP_P3_OFS,
                  a == `STP_P2_OFS, a == `STP_P1_OFS};
   endfunction : port_sel

   // class of a port from its three state controls
   function automatic stp_pkg::stp_class_e class_of(
      input logic [`STP_DATA_W-1:0] c
   );
      logic tx;
      logic rx;
      logic ld;
      tx = c[`STP_TX_EN_BIT];
      rx = c[`STP_RX_EN_BIT];
      ld = c[`STP_LRN_DIS_BIT];
      if (!tx && !rx && ld) begin
         class_of = stp_pkg::STP_DISCARD;
      end else if (!tx && !rx && !ld) begin
         class_of = stp_pkg::STP_LEARNING;
      end else if (tx && rx && !ld) begin
         class_of = stp_pkg::STP_FORWARDING;
      end else begin
         class_of = stp_pkg::STP_IRREGULAR;
      end
   endfunction : class_of

   ////////////////////////////////////////////////////////////////////////
   // registers

   logic [`STP_DATA_W-1:0] port_ctrl [NP];
   logic [`STP_DATA_W-1:0] global_ctrl;
   logic [`STP_DATA_W-1:0] status;
   logic [`STP_DATA_W-1:0] rd_mux;
   logic [NP-1:0]          wr_sel;
   logic [NP-1:0]          rd_sel;
   logic [NP-1:0]          tx_allow;
   logic [NP-1:0]          rx_en;
   logic [NP-1:0]          lrn_dis;
   logic                   wr_global;

   // write decode, shared with the read path through port_sel
   assign wr_sel    = REG_WR_I ? port_sel(REG_ADDR_I) : '0;
   assign wr_global = REG_WR_I & (REG_ADDR_I == `STP_GLOBAL_OFS);

   // RQ2 per-port controls
   // RQ14 one port each
   // each port keeps its own byte; a write touches only the selected one
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         for (int i = 0; i < NP; i++) begin
            port_ctrl[i] <= `STP_PORT_CTRL_RST;
         end
      end else if (CE_I) begin
         for (int i = 0; i < NP; i++) begin
            if (wr_sel[i]) begin
               port_ctrl[i] <= REG_WDATA_I;
            end
         end
      end
   end

   // RQ13 global tag enable
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         global_ctrl <= `STP_GLOBAL_RST;
      end else if (CE_I && wr_global) begin
         global_ctrl <= REG_WDATA_I;
      end
   end

   // per-port control fields and the read-only class status
   generate
      for (genvar g = 0; g < NP; g++) begin : g_port
         assign tx_allow[g] = port_ctrl[g][`STP_TX_EN_BIT];
         assign rx_en[g]    = port_ctrl[g][`STP_RX_EN_BIT];
         assign lrn_dis[g]  = port_ctrl[g][`STP_LRN_DIS_BIT];
         assign status[2*g +: 2] = class_of(port_ctrl[g]);
      end
   endgenerate

   // read select shares the port decode; unmapped addresses read as zero
   assign rd_sel = port_sel(REG_ADDR_I);
   assign rd_mux =
      rd_sel[0]                       ? port_ctrl[0] :
      rd_sel[1]                       ? port_ctrl[1] :
      rd_sel[2]                       ? port_ctrl[2] :
      rd_sel[3]                       ? port_ctrl[3] :
      (REG_ADDR_I == `STP_GLOBAL_OFS) ? global_ctrl  :
      (REG_ADDR_I == `STP_STATUS_OFS) ? status       :
      '0;

   // read data stand for the one cycle after the strobe only
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         REG_RDATA_O <= '0;
      end else if (CE_I) begin
         REG_RDATA_O <= REG_RD_I ? rd_mux : '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // forwarding decision

   logic                src_host;
   logic                src_port;
   logic [1:0]          src_idx;
   logic [NP-1:0]       self_mask;
   logic                tail_en;
   logic                directed;
   logic [4:0]          normal_mask;
   logic [4:0]          ovr_mask;
   logic [4:0]          fwd;
   logic                learn;
   logic [1:0]          queue;
   logic                push;
   stp_pkg::stp_dec_s   next_dec;

   // RQ1 host port apart
   // port five is never subject to a state, only ports one to four are
   assign src_host = FRM_I.src == `STP_HOST_PORT;
   assign src_port = (FRM_I.src != 3'h0) && (FRM_I.src < `STP_HOST_PORT);
   assign src_idx  = 2'(FRM_I.src - 3'h1);
   assign self_mask = src_port ? 4'(4'h1 << src_idx) : 4'h0;

   // RQ13 tag needs enable
   // RQ9 directed bypass
   // a reserved all-zero destination falls back to the normal lookup
   assign tail_en  = global_ctrl[`STP_TAILTAG_BIT];
   assign directed = src_host & tail_en & FRM_I.tag_v &
                     (FRM_I.tag[3:0] != 4'h0);

   // RQ12 normal forwarding
   // egress ports with transmit disabled are stripped, and so is the source port
   assign normal_mask = {FRM_I.dst[4] & ~src_host,
                         FRM_I.dst[3:0] & tx_allow & ~self_mask};

   // RQ4 override to host
   // RQ6 blocking override only
   assign ovr_mask = FRM_I.ovr ? `STP_HOST_MASK : 5'h00;

   // RQ3 disabled drops
   // RQ11 host traffic only
   // receive disabled leaves just the override path to the host
   assign fwd =
      directed                  ? {1'b0, FRM_I.tag[3:0]} :
      src_host                  ? normal_mask :
      src_port && rx_en[src_idx] ? normal_mask :
      src_port                  ? ovr_mask :
      5'h00;

   // RQ10 learning gate
   // host port learning is outside the state controls
   assign learn = src_host | (src_port & ~lrn_dis[src_idx]);
   assign queue = directed ? FRM_I.tag[5:4] : 2'h0;

   assign next_dec.src   = FRM_I.src;
   assign next_dec.fwd   = fwd;
   assign next_dec.learn = learn;
   assign next_dec.queue = queue;

   // RQ14 later frames only
   // controls are sampled at acceptance; a write in the same cycle
   // applies from the next frame on
   assign push = CE_I & FRM_VALID_I & FRM_READY_O;

   // the buffer absorbs one decision while queueing stalls
   stp_skid #(
      .W (DW)
   ) u_skid (
      .clk_i       (MCLK_I),
      .rst_n_i     (RST_N_I),
      .ce_i        (CE_I),
      .in_valid_i  (FRM_VALID_I),
      .in_data_i   (next_dec),
      .in_ready_o  (FRM_READY_O),
      .out_valid_o (DEC_VALID_O),
      .out_data_o  (DEC_O),
      .out_ready_i (DEC_READY_I)
   );

   ////////////////////////////////////////////////////////////////////////
   // checks

   property p_rq1;
      @(posedge MCLK_I) disable iff (!RST_N_I)
      push && src_host && !directed |->
         next_dec.learn && !next_dec.fwd[4];
   endproperty
   a_rq1: assert property (p_rq1) // RQ1
      else $error("host frame decision wrong");

   sequence s_rd_p1;
      CE_I && REG_RD_I && REG_ADDR_I == `STP_P1_OFS;
   endsequence
   property p_rq2;
      @(posedge MCLK_I) disable iff (!RST_N_I)
      s_rd_p1 |=> REG_RDATA_O == $past(port_ctrl[0]) ##1
         (REG_RDATA_O == '0 || $past(REG_RD_I));
   endproperty
   a_rq2: assert property (p_rq2) // RQ2
      else $error("port one control read back wrong");

   property p_rq3;
      @(posedge MCLK_I) disable iff (!RST_N_I)
      push && src_port && !rx_en[src_idx] && !FRM_I.ovr |->
         next_dec.fwd == 5'h00;
   endproperty
   a_rq3: assert property (p_rq3) // RQ3
      else $error("ordinary frame passed a closed port");

   property p_rq4;
      @(posedge MCLK_I) disable iff (!RST_N_I)
      push && src_port && !rx_en[src_idx] && FRM_I.ovr |->
         next_dec.fwd == `STP_HOST_MASK;
   endproperty
   a_rq4: assert property (p_rq4) // RQ4
      else $error("override frame not sent to host");

   property p_rq6;
      @(posedge MCLK_I) disable iff (!RST_N_I)
      push && src_port &&
      class_of(port_ctrl[src_idx]) == stp_pkg::STP_DISCARD |->
         next_dec.fwd[3:0] == 4'h0 && !next_dec.learn;
   endproperty
   a_rq6: assert property (p_rq6) // RQ6
      else $error("blocking port forwarded to a user port");

   property p_rq9;
      @(posedge MCLK_I) disable iff (!RST_N_I)
      push && src_host && tail_en && FRM_I.tag_v &&
      FRM_I.tag[3:0] != 4'h0 |->
         next_dec.fwd == {1'b0, FRM_I.tag[3:0]} &&
         next_dec.queue == FRM_I.tag[5:4];
   endproperty
   a_rq9: assert property (p_rq9) // RQ9
      else $error("directed frame not sent to tagged ports");

   property p_rq10;
      @(posedge MCLK_I) disable iff (!RST_N_I)
      push && src_port && lrn_dis[src_idx] |-> !next_dec.learn;
   endproperty
   a_rq10: assert property (p_rq10) // RQ10
      else $error("learning on a learning disabled port");

   property p_rq11;
      @(posedge MCLK_I) disable iff (!RST_N_I)
      push && src_port &&
      class_of(port_ctrl[src_idx]) == stp_pkg::STP_LEARNING |->
         next_dec.learn && next_dec.fwd[3:0] == 4'h0;
   endproperty
   a_rq11: assert property (p_rq11) // RQ11
      else $error("learning port passed user traffic");

   property p_rq12;
      @(posedge MCLK_I) disable iff (!RST_N_I)
      push && src_port &&
      class_of(port_ctrl[src_idx]) == stp_pkg::STP_FORWARDING |->
         next_dec.learn &&
         next_dec.fwd == {FRM_I.dst[4],
                          FRM_I.dst[3:0] & tx_allow & ~self_mask};
   endproperty
   a_rq12: assert property (p_rq12) // RQ12
      else $error("forwarding port decision wrong");

   property p_rq13;
      @(posedge MCLK_I) disable iff (!RST_N_I)
      push && src_host && !tail_en |->
         next_dec.fwd[3:0] == (FRM_I.dst[3:0] & tx_allow) &&
         next_dec.queue == 2'h0;
   endproperty
   a_rq13: assert property (p_rq13) // RQ13
      else $error("tail tag used while disabled");

   sequence s_close_p1;
      CE_I && REG_WR_I && REG_ADDR_I == `STP_P1_OFS &&
      !REG_WDATA_I[`STP_RX_EN_BIT];
   endsequence
   // a write lands at one edge; a frame offered after it is taken two later
   property p_rq14;
      @(posedge MCLK_I) disable iff (!RST_N_I)
      s_close_p1 ##2 (push && FRM_I.src == 3'h1 && !FRM_I.ovr) |->
         next_dec.fwd == 5'h00 && $stable(port_ctrl[1]);
   endproperty
   a_rq14: assert property (p_rq14) // RQ14
      else $error("closing port one not applied or leaked");

   property p_out;
      @(posedge MCLK_I) disable iff (!RST_N_I)
      push && !DEC_VALID_O |=> DEC_VALID_O && DEC_O == $past(next_dec);
   endproperty
   a_out: assert property (p_out)
      else $error("accepted decision did not appear");

   // read data fall back to zero unless a read was taken
   property p_rd_idle;
      @(posedge MCLK_I) disable iff (!RST_N_I)
      CE_I && !REG_RD_I |=> REG_RDATA_O == '0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) // RQ2
      else $error("read data stood without a read");

   // a low enable freezes every register, the read data included
   property p_freeze;
      @(posedge MCLK_I) disable iff (!RST_N_I)
      !CE_I |=> $stable(REG_RDATA_O) && $stable(global_ctrl) &&
         $stable(port_ctrl[0]) && $stable(port_ctrl[1]) &&
         $stable(port_ctrl[2]) && $stable(port_ctrl[3]);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("state moved while the clock enable was low");

endmodule : stp_port_state

// ===== verilog/stp_defines.svh
// register map, field positions and reset values of the port state block
// What this block and its host do
// RQ1: port five is host, outside state control
// RQ2: ports one to four own three controls
// RQ3: disabled port passes no ordinary frames
// RQ4: disabled port still sends override frames up
// RQ5: host sends none to, drops from disabled
// RQ6: blocking port forwards only override frames up
// RQ7: host transmits nothing toward blocking port
// RQ8: host loads override entries for such states
// RQ9: tail tag directed frames bypass transmit enable
// RQ10: learning disable stops source address learning
// RQ11: learning state learns, passes host traffic only
// RQ12: forwarding state forwards, receives and learns
// RQ13: tail tag honoured only when globally enabled
// RQ14: control change hits one port, later frames
`ifndef STP_DEFINES_SVH
`define STP_DEFINES_SVH

`define STP_ADDR_W         8
`define STP_DATA_W         8
`define STP_NUM_PORTS      4
`define STP_HOST_PORT      3'h5
`define STP_HOST_MASK      5'h10

`define STP_GLOBAL_OFS     8'h0c
`define STP_P1_OFS         8'h12
`define STP_P2_OFS         8'h22
`define STP_P3_OFS         8'h32
`define STP_P4_OFS         8'h42
`define STP_STATUS_OFS     8'hf0

`define STP_TAILTAG_BIT    1
`define STP_TX_EN_BIT      2
`define STP_RX_EN_BIT      1
`define STP_LRN_DIS_BIT    0

`define STP_PORT_CTRL_RST  8'h06
`define STP_GLOBAL_RST     8'h00

`endif

// ===== verilog/stp_pkg.sv
// types shared by the port state block, its host model and its bench
package stp_pkg;

   // decoded spanning tree class of one port
   typedef enum logic [1:0] {
      STP_DISCARD,
      STP_LEARNING,
      STP_FORWARDING,
      STP_IRREGULAR
   } stp_class_e;

   // frame descriptor offered by the lookup engine
   typedef struct packed {
      logic [2:0] src;
      logic [4:0] dst;
      logic       ovr;
      logic       tag_v;
      logic [7:0] tag;
   } stp_frame_s;

   // forwarding decision handed to the queue manager
   typedef struct packed {
      logic [2:0] src;
      logic [4:0] fwd;
      logic       learn;
      logic [1:0] queue;
   } stp_dec_s;

endpackage : stp_pkg

// ===== verilog/stp_skid.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
module stp_skid #(
   parameter int W = 8
) (
   // clock, reset and freeze
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         ce_i,
   // filling side
   input  wire logic         in_valid_i,
   input  wire logic [W-1:0] in_data_i,
   output logic              in_ready_o,
   // draining side
   output logic              out_valid_o,
   output logic [W-1:0]      out_data_o,
   input  wire logic         out_ready_i
);

   logic [W-1:0] skid;
   logic         accept;
   logic         room;

   // ready is the empty flag of the second entry, so it is a flop
   assign accept = in_valid_i & in_ready_o;
   assign room   = ~out_valid_o | out_ready_i;

   // the second entry catches the word that arrives during a stall
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_valid_o <= 1'b0;
         out_data_o  <= '0;
         skid        <= '0;
         in_ready_o  <= 1'b1;
      end else if (ce_i) begin
         if (!in_ready_o) begin
            if (out_ready_i) begin
               out_data_o <= skid;
               in_ready_o <= 1'b1;
            end
         end else if (room) begin
            out_valid_o <= accept;
            if (accept) begin
               out_data_o <= in_data_i;
            end
         end else if (accept) begin
            skid       <= in_data_i;
            in_ready_o <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   property p_hold;
      @(posedge clk_i) disable iff (!rst_n_i)
      ce_i && out_valid_o && !out_ready_i |=>
         out_valid_o && $stable(out_data_o);
   endproperty
   a_hold: assert property (p_hold)
      else $error("stalled output word changed");

   sequence s_fill;
      ce_i && out_valid_o && !out_ready_i && accept;
   endsequence
   property p_fill;
      @(posedge clk_i) disable iff (!rst_n_i)
      s_fill |=> !in_ready_o && skid == $past(in_data_i);
   endproperty
   a_fill: assert property (p_fill)
      else $error("second entry did not take stalled word");

endmodule : stp_skid

// ===== sim/stp_host_sink.sv
// host side model that takes decisions and drops frames of held ports
`timescale 1ns/1ns
module stp_host_sink (
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   // bench control
   input  wire logic              stall_i,
   input  wire logic [3:0]        down_i,
   // decision stream
   input  wire logic              dec_valid_i,
   input  wire stp_pkg::stp_dec_s dec_i,
   output logic                   dec_ready_o
);
   stp_pkg::stp_dec_s log [0:31];
   int                cnt;
   int                drops;
   logic              held;

   // stall on command so the buffer fills
   assign dec_ready_o = !stall_i;
   // a held port may still push override frames up; they are dropped
   assign held = dec_i.fwd[4] && dec_i.src inside {[3'h1:3'h4]}
                 && down_i[dec_i.src - 3'h1];

   ////////////////////////////////////////////////////////////////////
   // log every decision taken
   // host discards, sends none
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt   <= 0;
         drops <= 0;
      end else if (dec_valid_i && dec_ready_o) begin
         log[cnt] <= dec_i;
         cnt      <= cnt + 1;
         if (held) begin
            drops <= drops + 1;
         end
      end
   end
endmodule : stp_host_sink

// ===== sim/test_stp_port_state.sv
// self-checking bench for the spanning tree port state block
`timescale 1ns/1ns
module test_stp_port_state;
   logic                MCLK_I      = 1'b0;
   logic                RST_N_I     = 1'b0;
   logic                CE_I        = 1'b1;
   logic [7:0]          REG_ADDR_I  = 8'h00;
   logic [7:0]          REG_WDATA_I = 8'h00;
   logic                REG_WR_I    = 1'b0;
   logic                REG_RD_I    = 1'b0;
   logic [7:0]          REG_RDATA_O;
   logic                FRM_VALID_I = 1'b0;
   stp_pkg::stp_frame_s FRM_I       = '0;
   logic                FRM_READY_O;
   logic                DEC_VALID_O;
   stp_pkg::stp_dec_s   DEC_O;
   logic                DEC_READY_I;
   logic                stall       = 1'b0;
   logic [3:0]          down        = 4'h1;
   int                  err_count   = 0;
   int                  tests_run   = 0;
   int                  ri          = 0;

   // 50 MHz clock
   always #10 MCLK_I = ~MCLK_I;

   stp_port_state dut (
      .MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I),
      .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
      .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
      .REG_RDATA_O(REG_RDATA_O), .FRM_VALID_I(FRM_VALID_I),
      .FRM_I(FRM_I), .FRM_READY_O(FRM_READY_O),
      .DEC_VALID_O(DEC_VALID_O), .DEC_O(DEC_O),
      .DEC_READY_I(DEC_READY_I)
   );

   stp_host_sink sink (
      .clk_i(MCLK_I), .rst_n_i(RST_N_I), .stall_i(stall),
      .down_i(down), .dec_valid_i(DEC_VALID_O), .dec_i(DEC_O),
      .dec_ready_o(DEC_READY_I)
   );

   ////////////////////////////////////////////////////////////////////
   // verdict and end of run
   task automatic end_of_test;
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_of_test

   // byte and flag results
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk8

   // decision results
   task automatic chkd(input stp_pkg::stp_dec_s got,
                       input stp_pkg::stp_dec_s exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chkd

   // gap after the strobe keeps each strobe a single assignment per step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      REG_ADDR_I  <= a;
      REG_WDATA_I <= d;
      REG_WR_I    <= 1'b1;
      @(posedge MCLK_I);
      REG_WR_I    <= 1'b0;
      @(posedge MCLK_I);
   endtask : wr

   // read data only stand in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      REG_ADDR_I <= a;
      REG_RD_I   <= 1'b1;
      @(posedge MCLK_I);
      REG_RD_I   <= 1'b0;
      @(negedge MCLK_I);
      chk8(REG_RDATA_O, e);
      @(posedge MCLK_I);
   endtask : rd

   // offer one descriptor, hold it until ready is seen at an edge
   task automatic send(input logic [2:0] s, input logic [4:0] d,
                       input logic o, input logic v, input logic [7:0] t);
      logic r = 1'b0;
      int   n = 0;
      FRM_VALID_I <= 1'b1;
      FRM_I       <= {s, d, o, v, t};
      while (r !== 1'b1) begin
         if (n == 50) begin
            err_count++;
            end_of_test();
         end
         n++;
         @(negedge MCLK_I);
         r = FRM_READY_O;
         @(posedge MCLK_I);
      end
      FRM_VALID_I <= 1'b0;
      @(posedge MCLK_I);
   endtask : send

   // next decision logged by the host model, in order
   task automatic expd(input logic [2:0] s, input logic [4:0] f,
                       input logic l, input logic [1:0] q);
      int n = 0;
      while (sink.cnt <= ri) begin
         if (n == 50) begin
            err_count++;
            end_of_test();
         end
         n++;
         @(negedge MCLK_I);
      end
      chkd(sink.log[ri], {s, f, l, q});
      ri++;
      @(posedge MCLK_I);
   endtask : expd

   // hang guard
   initial begin
      #1000000;
      err_count++;
      end_of_test();
   end

   ////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (10) @(posedge MCLK_I);
      RST_N_I <= 1'b1;
      @(posedge MCLK_I);
      for (int i = 0; i < 4; i++) begin
         rd(8'h12 + 8'(i * 16), 8'h06);
      end
      rd(8'h0c, 8'h00);
      rd(8'hf0, 8'haa);
      rd(8'h55, 8'h00);
      // port 1 disabled, port 2 learning, port 4 upper bits stored
      wr(8'h12, 8'h01);
      wr(8'h22, 8'h00);
      wr(8'h42, 8'hfe);
      wr(8'hf0, 8'h00);
      rd(8'h42, 8'hfe);
      rd(8'h32, 8'h06);
      rd(8'hf0, 8'ha4);
      // a low clock enable ignores the write strobe
      CE_I <= 1'b0;
      wr(8'h22, 8'h06);
      CE_I <= 1'b1;
      rd(8'h22, 8'h00);
      // closing port one again reaches the very next frame
      wr(8'h12, 8'h01);
      // static override entries stand for what the host loaded
      // override marked frames
      send(3'h1, 5'h02, 1'b0, 1'b0, 8'h00);
      expd(3'h1, 5'h00, 1'b0, 2'h0);
      send(3'h1, 5'h02, 1'b1, 1'b0, 8'h00);
      expd(3'h1, 5'h10, 1'b0, 2'h0);
      send(3'h2, 5'h1d, 1'b0, 1'b0, 8'h00);
      expd(3'h2, 5'h00, 1'b1, 2'h0);
      send(3'h2, 5'h1d, 1'b1, 1'b0, 8'h00);
      expd(3'h2, 5'h10, 1'b1, 2'h0);
      send(3'h3, 5'h1f, 1'b0, 1'b0, 8'h00);
      expd(3'h3, 5'h18, 1'b1, 2'h0);
      // host frames aim at ports that are not held; the tail tag directed one reaches port 2, whose transmit is disabled
      send(3'h5, 5'h0e, 1'b0, 1'b0, 8'h00);
      expd(3'h5, 5'h0c, 1'b1, 2'h0);
      send(3'h5, 5'h0e, 1'b0, 1'b1, 8'h32);
      expd(3'h5, 5'h0c, 1'b1, 2'h0);
      wr(8'h0c, 8'h02);
      rd(8'h0c, 8'h02);
      send(3'h5, 5'h0e, 1'b0, 1'b1, 8'h32);
      expd(3'h5, 5'h02, 1'b1, 2'h3);
      send(3'h5, 5'h0e, 1'b0, 1'b1, 8'h20);
      expd(3'h5, 5'h0c, 1'b1, 2'h0);
      // change to port 3 reaches later frames of port 3 and strips port 3 from the frames of port 4
      wr(8'h32, 8'h01);
      send(3'h3, 5'h1f, 1'b0, 1'b0, 8'h00);
      expd(3'h3, 5'h00, 1'b0, 2'h0);
      send(3'h4, 5'h1f, 1'b0, 1'b0, 8'h00);
      expd(3'h4, 5'h10, 1'b1, 2'h0);
      // host stalls: two words fill the buffer, none is lost
      stall <= 1'b1;
      send(3'h4, 5'h01, 1'b0, 1'b0, 8'h00);
      send(3'h5, 5'h08, 1'b0, 1'b0, 8'h00);
      @(negedge MCLK_I);
      chk8({7'h00, FRM_READY_O}, 8'h00);
      @(posedge MCLK_I);
      stall <= 1'b0;
      expd(3'h4, 5'h00, 1'b1, 2'h0);
      expd(3'h5, 5'h08, 1'b1, 2'h0);
      @(negedge MCLK_I);
      chk8({7'h00, FRM_READY_O}, 8'h01);
      chk8(8'(sink.drops), 8'h01);
      end_of_test();
   end
endmodule : test_stp_port_state
